// ===== display_output.v
// Display output block: parallel panel timing, serial panel and
// embedded link muxing, backlight, attach detection, id bus pins.
// Assumes the pixel reference clock and pin inputs are asynchronous
// to mclk; serialisers and pin buffers sit outside this block.
`include "display_out_defines.vh"

// ****************************************************************
// Pixel FIFO
// ****************************************************************
module pixel_fifo #(
   parameter WIDTH = 24,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire             mclk,
   input  wire             rst,
   input  wire [WIDTH-1:0] inData,
   input  wire             inValid,
   output wire             inReady,
   output reg  [WIDTH-1:0] outData,
   output wire             outValid,
   input  wire             outReady
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];    // Storage in flip-flops
   reg [AW:0]      wrPtr_r;            // Write pointer, wrap bit on top
   reg [AW:0]      rdPtr_r;            // Read pointer, wrap bit on top
   wire            fullW;
   wire            emptyW;
   wire            pushW;
   wire            popW;
   integer         i;

   assign emptyW   = (wrPtr_r == rdPtr_r);
   assign fullW    = (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]) &&
                     (wrPtr_r[AW] != rdPtr_r[AW]);
   assign inReady  = ~fullW;
   assign outValid = ~emptyW;
   assign pushW    = inValid & ~fullW;
   assign popW     = outReady & ~emptyW;

   // Data output read from the head entry
   always @* begin
      outData = mem[rdPtr_r[AW-1:0]];
   end

   // Pointer and storage update
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         wrPtr_r <= {(AW+1){1'b0}};
         rdPtr_r <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] <= {WIDTH{1'b0}};
         end
      end else begin
         if (pushW) begin
            mem[wrPtr_r[AW-1:0]] <= inData;
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (popW) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
      end
   end
endmodule // pixel_fifo

// ****************************************************************
// Display output top
// ****************************************************************
module display_output #(
   parameter FIFO_DEPTH = 32,
   parameter FIFO_AW    = 5
) (
   input  wire        mclk,
   input  wire        rst,
   // Pixel reference clock from outside
   input  wire        pixRefClk,
   // Pixel stream in
   input  wire [23:0] pixData,
   input  wire        pixValid,
   output wire        pixReady,
   // Controls
   input  wire        parPanelPowerReq,
   input  wire        serialPanelPowerReq,
   input  wire        useEmbeddedLink,
   input  wire        backlightReq,
   input  wire [7:0]  brightness,
   // Parallel panel
   output wire [7:0]  parRed,
   output wire [7:0]  parGreen,
   output wire [7:0]  parBlue,
   output reg         parHsync,
   output reg         parVsync,
   output reg         parActiveVideo,
   output reg         parPixelClock,
   output reg         parPanelPower,
   output reg         backlightOn,
   output reg         backlightDimming,
   output reg         pixUnderrun,
   // Serial panel / embedded link to the shared serialiser
   output reg  [23:0] serialPanelPixel,
   output reg         serialPanelDe,
   output reg         serialPanelSelect,
   output reg         embeddedLinkSelect,
   output reg         sharedPanelPower,
   // Sink link word to the transition-minimised serialiser
   output reg  [23:0] sinkLinkPixel,
   output reg         sinkLinkDe,
   // Attach detect
   input  wire        embeddedLinkAttachDetect,
   output reg         embeddedLinkAttached,
   input  wire        sinkAttachDetect,
   output reg         sinkAttached,
   output reg         sinkAttachEvent,
   output reg         sinkDetachEvent,
   // Panel id bus, open drain
   input  wire        panelIdBusClockDriveLow,
   input  wire        panelIdBusDataDriveLow,
   input  wire        panelIdBusClockIn,
   input  wire        panelIdBusDataIn,
   output wire        panelIdBusClockOut,
   output wire        panelIdBusClockOe,
   output wire        panelIdBusDataOut,
   output wire        panelIdBusDataOe,
   output reg         panelIdClockSeen,
   output reg         panelIdDataSeen,
   // Sink id bus, open drain
   input  wire        sinkIdBusClockDriveLow,
   input  wire        sinkIdBusDataDriveLow,
   input  wire        sinkIdBusClockIn,
   input  wire        sinkIdBusDataIn,
   output wire        sinkIdBusClockOut,
   output wire        sinkIdBusClockOe,
   output wire        sinkIdBusDataOut,
   output wire        sinkIdBusDataOe,
   output reg         sinkIdClockSeen,
   output reg         sinkIdDataSeen,
   // Single-wire control line
   input  wire        sinkControlWireDrive,
   input  wire        sinkControlWireLevel,
   input  wire        sinkControlWireIn,
   output wire        sinkControlWireOut,
   output wire        sinkControlWireOe,
   output reg         sinkControlWireSeen
);
   localparam HTOT = `H_SYNC + `H_BACK + `H_ACTIVE + `H_FRONT;
   localparam VTOT = `V_SYNC + `V_BACK + `V_ACTIVE + `V_FRONT;
   localparam HA0  = `H_SYNC + `H_BACK;        // First active column
   localparam VA0  = `V_SYNC + `V_BACK;        // First active row

   reg  [1:0]  refSync_r;          // Pixel reference synchroniser
   reg  [1:0]  eHpdSync_r;         // Embedded attach synchroniser
   reg  [1:0]  sHpdSync_r;         // Sink attach synchroniser
   reg  [1:0]  pIdSync_r;          // Panel id bus readback
   reg  [1:0]  sIdSync_r;          // Sink id bus readback
   reg  [1:0]  cecSync_r;          // Control wire readback
   reg  [1:0]  pIdDatSync_r;       // Panel id data readback
   reg  [1:0]  sIdDatSync_r;       // Sink id data readback
   reg  [11:0] hCnt_r;             // Column counter
   reg  [11:0] vCnt_r;             // Row counter
   reg  [11:0] hCnt_nxt;
   reg  [11:0] vCnt_nxt;
   reg  [23:0] pixOut_r;           // Launched colour word
   reg  [7:0]  pwmCnt_r;           // Backlight PWM phase
   wire        stepW;              // Pixel clock rising edge
   wire        deNxtW;
   wire [23:0] fifoData;
   wire        fifoValid;
   wire        popW;
   wire [23:0] pixNxtW;

   // *************************************************************
   // Pixel FIFO in the data path
   // *************************************************************
   pixel_fifo #(
      .WIDTH (24),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) uFifo (
      .mclk     (mclk),
      .rst      (rst),
      .inData   (pixData),
      .inValid  (pixValid),
      .inReady  (pixReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (popW)
   );

   // *************************************************************
   // Input synchronisers
   // *************************************************************
   // Two flops per asynchronous input
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         refSync_r  <= 2'h0;
         eHpdSync_r <= 2'h0;
         sHpdSync_r <= 2'h0;
         pIdSync_r  <= 2'h3;
         sIdSync_r  <= 2'h3;
         cecSync_r  <= 2'h3;
         pIdDatSync_r <= 2'h3;
         sIdDatSync_r <= 2'h3;
      end else begin
         refSync_r  <= {refSync_r[0], pixRefClk};
         eHpdSync_r <= {eHpdSync_r[0], embeddedLinkAttachDetect};
         sHpdSync_r <= {sHpdSync_r[0], sinkAttachDetect};
         pIdSync_r  <= {pIdSync_r[0], panelIdBusClockIn};
         sIdSync_r  <= {sIdSync_r[0], sinkIdBusClockIn};
         cecSync_r  <= {cecSync_r[0], sinkControlWireIn};
         pIdDatSync_r <= {pIdDatSync_r[0], panelIdBusDataIn};
         sIdDatSync_r <= {sIdDatSync_r[0], sinkIdBusDataIn};
      end
   end

   // Rising edge of the synchronised reference
   assign stepW = refSync_r[1] & ~parPixelClock;

   // *************************************************************
   // Line and frame counters
   // *************************************************************
   // Next column and row on each pixel step
   always @* begin
      hCnt_nxt = hCnt_r;
      vCnt_nxt = vCnt_r;
      if (stepW) begin
         if (hCnt_r == HTOT - 1) begin
            hCnt_nxt = 12'h000;
            if (vCnt_r == VTOT - 1) begin
               vCnt_nxt = 12'h000;
            end else begin
               vCnt_nxt = vCnt_r + 12'h001;
            end
         end else begin
            hCnt_nxt = hCnt_r + 12'h001;
         end
      end
   end

   // Active region of the upcoming pixel
   assign deNxtW = (hCnt_nxt >= HA0) && (hCnt_nxt < HA0 + `H_ACTIVE) &&
                   (vCnt_nxt >= VA0) && (vCnt_nxt < VA0 + `V_ACTIVE);
   assign popW    = stepW & deNxtW;
   assign pixNxtW = fifoValid ? fifoData : `PIX_RESET;

   // *************************************************************
   // Parallel panel launch
   // *************************************************************
   // Colour, sync and active video change together on the pixel clock rise
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         hCnt_r         <= 12'h000;
         vCnt_r         <= 12'h000;
         parPixelClock  <= 1'b0;
         parHsync       <= 1'b0;
         parVsync       <= 1'b0;
         parActiveVideo <= 1'b0;
         pixOut_r       <= `PIX_RESET;
         pixUnderrun    <= 1'b0;
      end else begin
         hCnt_r        <= hCnt_nxt;
         vCnt_r        <= vCnt_nxt;
         parPixelClock <= refSync_r[1];
         pixUnderrun   <= popW & ~fifoValid;
         if (stepW) begin
            parHsync       <= (hCnt_nxt < `H_SYNC);
            parVsync       <= (vCnt_nxt < `V_SYNC);
            parActiveVideo <= deNxtW;
            pixOut_r       <= deNxtW ? pixNxtW : `PIX_RESET;
         end
      end
   end

   // Colour fields, bit 7 most significant
   assign parRed   = pixOut_r[`RED_LSB +: `CHAN_BITS];
   assign parGreen = pixOut_r[`GREEN_LSB +: `CHAN_BITS];
   assign parBlue  = pixOut_r[`BLUE_LSB +: `CHAN_BITS];

   // *************************************************************
   // Shared serial panel / embedded link and sink link
   // *************************************************************
   // Mode mux and word routing to the serialisers
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         serialPanelPixel   <= `PIX_RESET;
         serialPanelDe      <= 1'b0;
         serialPanelSelect  <= 1'b0;
         embeddedLinkSelect <= 1'b0;
         sharedPanelPower   <= 1'b0;
         sinkLinkPixel      <= `PIX_RESET;
         sinkLinkDe         <= 1'b0;
         parPanelPower      <= 1'b0;
      end else begin
         serialPanelSelect  <= ~useEmbeddedLink;
         embeddedLinkSelect <= useEmbeddedLink;
         serialPanelPixel   <= pixOut_r;
         serialPanelDe      <= parActiveVideo;
         sinkLinkPixel      <= pixOut_r;
         sinkLinkDe         <= parActiveVideo;
         sharedPanelPower   <= serialPanelPowerReq;
         parPanelPower      <= parPanelPowerReq;
      end
   end

   // *************************************************************
   // Backlight
   // *************************************************************
   // Free-running PWM, duty set by brightness
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         pwmCnt_r         <= 8'h00;
         backlightOn      <= 1'b0;
         backlightDimming <= 1'b0;
      end else begin
         pwmCnt_r         <= pwmCnt_r + 8'h01;
         backlightOn      <= backlightReq;
         backlightDimming <= backlightReq && (pwmCnt_r < brightness);
      end
   end

   // *************************************************************
   // Attach detection
   // *************************************************************
   // Embedded attach only in embedded mode; sink changes as pulses
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         embeddedLinkAttached <= 1'b0;
         sinkAttached         <= 1'b0;
         sinkAttachEvent      <= 1'b0;
         sinkDetachEvent      <= 1'b0;
      end else begin
         embeddedLinkAttached <= useEmbeddedLink & eHpdSync_r[1];
         sinkAttached         <= sHpdSync_r[1];
         sinkAttachEvent      <= sHpdSync_r[1] & ~sinkAttached;
         sinkDetachEvent      <= ~sHpdSync_r[1] & sinkAttached;
      end
   end

   // *************************************************************
   // Open-drain id buses and control wire
   // *************************************************************
   // Panel bus only driven in serial panel mode
   assign panelIdBusClockOut = 1'b0;
   assign panelIdBusClockOe  = panelIdBusClockDriveLow & ~useEmbeddedLink;
   assign panelIdBusDataOut  = 1'b0;
   assign panelIdBusDataOe   = panelIdBusDataDriveLow & ~useEmbeddedLink;
   assign sinkIdBusClockOut  = 1'b0;
   assign sinkIdBusClockOe   = sinkIdBusClockDriveLow;
   assign sinkIdBusDataOut   = 1'b0;
   assign sinkIdBusDataOe    = sinkIdBusDataDriveLow;
   assign sinkControlWireOut = sinkControlWireLevel;
   assign sinkControlWireOe  = sinkControlWireDrive;

   // Registered readback of the line levels
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         panelIdClockSeen    <= 1'b1;
         panelIdDataSeen     <= 1'b1;
         sinkIdClockSeen     <= 1'b1;
         sinkIdDataSeen      <= 1'b1;
         sinkControlWireSeen <= 1'b1;
      end else begin
         panelIdClockSeen    <= pIdSync_r[1];
         panelIdDataSeen     <= pIdDatSync_r[1];
         sinkIdClockSeen     <= sIdSync_r[1];
         sinkIdDataSeen      <= sIdDatSync_r[1];
         sinkControlWireSeen <= cecSync_r[1];
      end
   end
endmodule // display_output

// ===== display_out_defines.vh
// Timing and reset constants for the display output block.
// Assumes inclusion by bare name from the design file.
`ifndef DISPLAY_OUT_DEFINES_VH
`define DISPLAY_OUT_DEFINES_VH
// ****************************************************************
// Line timing in pixel clocks, frame timing in lines
// ****************************************************************
`define H_SYNC      16
`define H_BACK      8
`define H_ACTIVE    64
`define H_FRONT     8
`define V_SYNC      2
`define V_BACK      2
`define V_ACTIVE    8
`define V_FRONT     2
// ****************************************************************
// Colour layout and reset values
// ****************************************************************
`define CHAN_BITS   8
`define RED_LSB     16
`define GREEN_LSB   8
`define BLUE_LSB    0
`define PIX_RESET   24'h000000
`define PWM_BITS    8
`endif

// ===== display_output_monitor.sv
// Port checker for the display output block.
// Assumes a bind into display_output; sees only that module's ports.
module display_output_monitor (
   input wire        mclk, rst, parPanelPowerReq, parPanelPower,
   input wire        backlightReq, backlightOn, useEmbeddedLink,
   input wire        serialPanelSelect, embeddedLinkSelect,
   input wire [7:0]  parRed, parGreen, parBlue,
   input wire        parHsync, parVsync, parActiveVideo, parPixelClock,
   input wire        embeddedLinkAttached, sinkAttachDetect,
   input wire        sinkAttachEvent, sinkDetachEvent, pixUnderrun,
   input wire [23:0] serialPanelPixel, sinkLinkPixel,
   input wire        serialPanelDe, sinkLinkDe,
   input wire        sinkIdBusClockDriveLow, sinkIdBusDataDriveLow,
   input wire        sinkIdBusClockOe, sinkIdBusDataOe,
   input wire        sinkIdBusClockOut, sinkIdBusDataOut,
   input wire        panelIdBusClockDriveLow, panelIdBusClockOe,
   input wire        sinkControlWireDrive, sinkControlWireLevel,
   input wire        sinkControlWireOut, sinkControlWireOe
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // Properties, all in the mclk domain
   // ****************************************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   property p_pow; !$past(rst) |-> parPanelPower == $past(parPanelPowerReq);
   endproperty
   a_pow: assert property (p_pow) else $error("panel power lag");
   property p_bl; !$past(rst) |-> backlightOn == $past(backlightReq);
   endproperty
   a_bl: assert property (p_bl) else $error("backlight enable");
   property p_sel; !$past(rst) |-> embeddedLinkSelect == $past(useEmbeddedLink)
      && serialPanelSelect == !$past(useEmbeddedLink); endproperty
   a_sel: assert property (p_sel) else $error("mode select");
   property p_black; !parActiveVideo |-> {parRed, parGreen, parBlue} == 0;
   endproperty
   a_black: assert property (p_black) else $error("colour off DE");
   property p_align; !$stable({parRed, parGreen, parBlue, parHsync, parVsync,
      parActiveVideo}) |-> $rose(parPixelClock); endproperty
   a_align: assert property (p_align) else $error("launch edge");
   property p_emb; !useEmbeddedLink && !$past(useEmbeddedLink)
      |=> !embeddedLinkAttached; endproperty
   a_emb: assert property (p_emb) else $error("attach in serial");
   property p_ev; $rose(sinkAttachDetect) |-> ##[1:6] sinkAttachEvent;
   endproperty
   a_ev: assert property (p_ev) else $error("attach event late");
   property p_copy; !$past(rst) |-> serialPanelPixel ==
      $past({parRed, parGreen, parBlue}) && sinkLinkPixel == serialPanelPixel
      && serialPanelDe == $past(parActiveVideo) && sinkLinkDe == serialPanelDe;
   endproperty
   a_copy: assert property (p_copy) else $error("link word copy");
   property p_sid; sinkIdBusClockOe == sinkIdBusClockDriveLow && !sinkIdBusDataOut
      && sinkIdBusDataOe == sinkIdBusDataDriveLow && !sinkIdBusClockOut;
   endproperty
   a_sid: assert property (p_sid) else $error("sink id open drain");
   property p_gate; !$past(rst) && useEmbeddedLink == $past(useEmbeddedLink)
      |-> panelIdBusClockOe == (panelIdBusClockDriveLow && !useEmbeddedLink);
   endproperty
   a_gate: assert property (p_gate) else $error("panel id gating");
   property p_cec; sinkControlWireOe == sinkControlWireDrive
      && sinkControlWireOut == sinkControlWireLevel; endproperty
   a_cec: assert property (p_cec) else $error("control wire");
   c_de: cover property ($rose(parActiveVideo));
   c_under: cover property (pixUnderrun);
   c_det: cover property (sinkDetachEvent);
endmodule // display_output_monitor

// ===== panel_model.sv
// Far-side model: panel timing capture, reference clock, pins.
// Assumes the testbench connects it by name beside the design.
module panel_model (
   input  wire        mclk, run, plugIn, parPixelClock, parHsync,
   input  wire        parVsync, parActiveVideo,
   input  wire [7:0]  parRed, parGreen, parBlue,
   input  wire        panelIdBusClockOe, panelIdBusDataOe,
   input  wire        sinkIdBusClockOe, sinkIdBusDataOe,
   input  wire        sinkControlWireOe, sinkControlWireOut,
   output logic       pixRefClk,
   output wire        sinkAttachDetect, embeddedLinkAttachDetect,
   output wire        panelIdBusClockIn, panelIdBusDataIn,
   output wire        sinkIdBusClockIn, sinkIdBusDataIn, sinkControlWireIn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        pPrev = 0, hPrev = 0, vPrev = 0, cecRel = 0, dPrev = 0;
   logic [17:0] cap18[$];                    // What an 18-bit panel sees
   int          col, row, deCol, deRow, nH, nV, nDe, lastH, lastV, lastDe;
   int          frames;
   logic [23:0] cap[$];                      // Active pixels seen
   wire  [17:0] panel18 = {parRed[7:2], parGreen[7:2], parBlue[7:2]};
   // Pulled-up lines low only while driven
   assign panelIdBusClockIn = !panelIdBusClockOe;
   assign panelIdBusDataIn = !panelIdBusDataOe;
   assign sinkIdBusClockIn = !sinkIdBusClockOe;
   assign sinkIdBusDataIn = !sinkIdBusDataOe;
   // Released wire shows a changing pattern
   assign sinkControlWireIn = sinkControlWireOe ? sinkControlWireOut : cecRel;
   assign sinkAttachDetect = plugIn;
   assign embeddedLinkAttachDetect = plugIn;
   // Reference clock stands still while not running
   initial begin
      pixRefClk = 0;
      #37;
      forever #400 pixRefClk = run ? !pixRefClk : 1'b0;
   end
   // Pixel capture at each rising panel clock
   always @(negedge mclk) begin
      cecRel <= !cecRel;
      pPrev <= parPixelClock;
      if (parPixelClock && !pPrev) begin
         col = (parHsync && !hPrev) ? 0 : col + 1;
         if (parHsync && !hPrev) row = (parVsync && !vPrev) ? 0 : row + 1;
         if (parVsync && !vPrev) begin
            lastH = nH; lastV = nV; lastDe = nDe;
            nH = 0; nV = 0; nDe = 0; frames++;
         end
         if (parActiveVideo && !dPrev) deCol = col;
         if (parActiveVideo && nDe == 0) deRow = row;
         nH += parHsync; nV += parVsync; nDe += parActiveVideo;
         if (parActiveVideo) cap.push_back({parRed, parGreen, parBlue});
         if (parActiveVideo) cap18.push_back(panel18);
         hPrev = parHsync; vPrev = parVsync; dPrev = parActiveVideo;
      end
   end
endmodule // panel_model

// ===== display_output_tb.sv
// Self-checking bench for the display output block.
// Assumes the design, its defines header, model and checker.
`include "display_out_defines.vh"
module display_output_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic [23:0] pixData, serialPanelPixel, sinkLinkPixel;
   logic [7:0]  brightness, parRed, parGreen, parBlue;
   logic mclk = 0, rst, pixRefClk, pixValid, pixReady, parPanelPowerReq,
      serialPanelPowerReq, useEmbeddedLink, backlightReq, parHsync, parVsync,
      parActiveVideo, parPixelClock, parPanelPower, backlightOn,
      backlightDimming, pixUnderrun, serialPanelDe, serialPanelSelect,
      embeddedLinkSelect, sharedPanelPower, sinkLinkDe, sinkAttached,
      embeddedLinkAttachDetect, embeddedLinkAttached, sinkAttachDetect,
      sinkAttachEvent, sinkDetachEvent, panelIdBusClockDriveLow,
      panelIdBusDataDriveLow, panelIdBusClockIn, panelIdBusDataIn,
      panelIdBusClockOut, panelIdBusClockOe, panelIdBusDataOut,
      panelIdBusDataOe, panelIdClockSeen, panelIdDataSeen,
      sinkIdBusClockDriveLow, sinkIdBusDataDriveLow, sinkIdBusClockIn,
      sinkIdBusDataIn, sinkIdBusClockOut, sinkIdBusClockOe, sinkIdBusDataOut,
      sinkIdBusDataOe, sinkIdClockSeen, sinkIdDataSeen, sinkControlWireDrive,
      sinkControlWireLevel, sinkControlWireIn, sinkControlWireOut,
      sinkControlWireOe, sinkControlWireSeen, run, plugIn;
   int failures, nTests, n;
   // Full line length in pixel steps, frame length in rows
   localparam int lineLen = `H_SYNC + `H_BACK + `H_ACTIVE + `H_FRONT;
   localparam int frameRows = `V_SYNC + `V_BACK + `V_ACTIVE + `V_FRONT;
   display_output display_output_i (.*);
   panel_model panel_model_i (.*);
   always #50 mclk = !mclk;
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic check(input string what, input logic [31:0] seen, exp);
      nTests++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", nTests, failures);
      if (failures == 0 && nTests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task t_controls;
      for (int k = 0; k < 16; k++) begin
         {parPanelPowerReq, serialPanelPowerReq, backlightReq,
            useEmbeddedLink} = k[3:0];
         cyc(2);
         check("panelPower", parPanelPower, k[3]);
         check("sharedPower", sharedPanelPower, k[2]);
         check("backlight", backlightOn, k[1]);
         check("embSel", embeddedLinkSelect, k[0]);
         check("serSel", serialPanelSelect, !k[0]);
      end
   endtask
   task t_pwm;
      logic [7:0] tab [3];
      tab = '{8'h00, 8'h40, 8'hff};
      foreach (tab[i]) begin
         brightness = tab[i];
         cyc(4);
         n = 0;
         repeat (256) begin @(negedge mclk); n += backlightDimming; end
         check("dutyHigh", n, tab[i]);
      end
   endtask
   task t_pins;
      for (int k = 0; k < 4; k++) begin
         {useEmbeddedLink, panelIdBusClockDriveLow} = k[1:0];
         {panelIdBusDataDriveLow, sinkIdBusClockDriveLow} = {2{k[0]}};
         {sinkIdBusDataDriveLow, sinkControlWireDrive} = {k[0], 1'b1};
         sinkControlWireLevel = !k[0];
         cyc(5);
         check("panelClkSeen", panelIdClockSeen, k != 1);
         check("panelDatSeen", panelIdDataSeen, k != 1);
         check("sinkClkSeen", sinkIdClockSeen, !k[0]);
         check("sinkDatSeen", sinkIdDataSeen, !k[0]);
         check("wireSeen", sinkControlWireSeen, !k[0]);
         check("idPinsOut", {panelIdBusClockOut, panelIdBusDataOut}, 0);
      end
   endtask
   task t_attach;
      for (int k = 0; k < 2; k++) begin
         useEmbeddedLink = k;
         cyc(2);
         plugIn = 1;
         n = 0;
         repeat (8) begin @(negedge mclk); n += sinkAttachEvent; end
         check("attachEvents", n, 1);
         check("attached", sinkAttached, 1);
         check("embAttached", embeddedLinkAttached, k);
         plugIn = 0;
         n = 0;
         repeat (8) begin @(negedge mclk); n += sinkDetachEvent; end
         check("detachEvents", n, 1);
         check("attachedOff", sinkAttached, 0);
      end
      useEmbeddedLink = 0;
   endtask
   task t_stream;
      logic [23:0] e;
      logic [17:0] e18;
      for (n = 0; n < 40 && pixReady === 1'b1; n++) begin
         pixData = {n[7:0], ~n[7:0], n[7:0] ^ 8'h5a};
         pixValid = 1;
         @(negedge mclk);
      end
      pixValid = 0;
      check("wordsTaken", n, 32);
      cyc(20);
      check("stalledReady", pixReady, 0);
      run = 1;
      n = 0;
      // First frame is entered one column late; judge the second
      for (int w = 0; w < 30000 && panel_model_i.frames < 3; w++) begin
         cyc(1);
         n += pixUnderrun;
      end
      check("underruns", n, 2 * `H_ACTIVE * `V_ACTIVE - 32);
      for (int i = 0; i < 32; i++) begin
         e = {i[7:0], ~i[7:0], i[7:0] ^ 8'h5a};
         e18 = {e[23:18], e[15:10], e[7:2]};
         check("pixel", panel_model_i.cap[i], e);
         check("pixel18", panel_model_i.cap18[i], e18);
      end
      check("hsyncSteps", panel_model_i.lastH, `H_SYNC * frameRows);
      check("vsyncSteps", panel_model_i.lastV, `V_SYNC * lineLen);
      check("deSteps", panel_model_i.lastDe, `H_ACTIVE * `V_ACTIVE);
      check("deColumn", panel_model_i.deCol, `H_SYNC + `H_BACK);
      check("deRow", panel_model_i.deRow, `V_SYNC + `V_BACK);
      check("drainedReady", pixReady, 1);
   endtask
   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   initial begin
      {rst, pixData, pixValid, brightness, run, plugIn} = {1'b1, 35'h0};
      {parPanelPowerReq, serialPanelPowerReq, useEmbeddedLink} = 3'h0;
      {backlightReq, panelIdBusClockDriveLow, panelIdBusDataDriveLow} = 3'h0;
      {sinkIdBusClockDriveLow, sinkIdBusDataDriveLow} = 2'h0;
      {sinkControlWireDrive, sinkControlWireLevel} = 2'h0;
      cyc(8);
      rst = 0;
      cyc(1);
      check("readyAfterReset", pixReady, 1);
      check("deAfterReset", parActiveVideo, 0);
      t_controls;
      t_pwm;
      t_pins;
      t_attach;
      t_stream;
      end_of_test;
   end
   initial begin
      repeat (60000) @(posedge mclk);
      failures++;
      end_of_test;
   end
endmodule // display_output_tb
bind display_output display_output_monitor display_output_monitor_i (.*);
